// File: src/demod_gate_pkg.sv
// shared constants and carrier types for the demodulator gate timing
package demod_gate_pkg;

   // ----------------------------------------------------------------
   // multiplied timing clock
   // ----------------------------------------------------------------
   localparam int unsigned PLL_RATIO      = 10;   // timing ticks per segment period
   localparam int unsigned TICK_W         = 4;
   localparam logic [3:0]  TICK_MAX       = 4'(PLL_RATIO - 1);
   localparam logic [3:0]  GATE_START_DEF = 4'h1; // first tick after an edge with gate on
   localparam logic [3:0]  GATE_STOP_DEF  = 4'h4; // first tick with gate off again

   // ----------------------------------------------------------------
   // status LED dividers (rising edges of the sensor per LED toggle)
   // ----------------------------------------------------------------
   localparam int unsigned PHASE_LED_DIV  = 15;   // 30 rev/s wheel gives about 2 toggles/s
   localparam int unsigned SEG_LED_DIV    = 60;
   localparam int unsigned LED_CNT_W      = 8;

   // ----------------------------------------------------------------
   // sample path
   // ----------------------------------------------------------------
   localparam int unsigned SAMPLE_W       = 12;
   localparam int unsigned SYNC_STAGES    = 3;

   // one enable per sample-and-hold gate
   typedef struct packed {
      logic ref_dark;
      logic ref_bright;
      logic meas_dark;
      logic meas_bright;
   } gate_t;

   // conditioned sensor levels as one bundle
   typedef struct packed {
      logic dark_cal_req;
      logic timing_clk;
      logic segment;
      logic wheel_phase;
   } sensor_t;

endpackage

// File: src/input_sync.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module input_sync
   import demod_gate_pkg::*;
#(
   parameter int unsigned WIDTH = 4
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // raw and conditioned levels
   input  wire logic [WIDTH-1:0] raw_in,
   output logic      [WIDTH-1:0] level_out
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // ----------------------------------------------------------------
   // shift chain, stage1 feeds stage2 only
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= raw_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // per bit agreement filter, rejects a single-cycle glitch
   genvar b;
   generate
      for (b = 0; b < WIDTH; b++) begin : g_bit
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               level_out[b] <= 1'b0;
            end else if (stage2[b] == stage3[b]) begin
               level_out[b] <= stage3[b];
            end
         end
      end
   endgenerate

endmodule

// File: src/demod_gate_timing.sv
// gate timing, level hold, status LEDs and dark switch of the sync demodulator
// Contract
// - four gates: phase half times segment level
// - gates follow segment and wheel-phase sensors
// - timing ticks come from the tenfold locked clock
// - gates only in centre, never near edges
// - hold measure and reference peak levels
// - LEDs toggle with phase and segment rotation
// - dark calibration opens the detector switch
`timescale 1ns/1ns
module demod_gate_timing
   import demod_gate_pkg::*;
#(
   parameter logic [3:0]  GATE_START = GATE_START_DEF,
   parameter logic [3:0]  GATE_STOP  = GATE_STOP_DEF,
   parameter int unsigned PHASE_DIV  = PHASE_LED_DIV,
   parameter int unsigned SEG_DIV    = SEG_LED_DIV
) (
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                rst,
   // sensor pins and host request (asynchronous)
   input  wire logic                wheel_phase_in,
   input  wire logic                segment_in,
   input  wire logic                timing_clk_in,
   input  wire logic                dark_cal_req_in,
   // digitised detector signal, same clock domain
   input  wire logic [SAMPLE_W-1:0] detector_sample,
   // sample-and-hold enables
   output gate_t                    gates,
   // held levels for conversion
   output logic      [SAMPLE_W-1:0] measure_level_out,
   output logic      [SAMPLE_W-1:0] reference_level_out,
   // status and switch
   output logic                     wheel_phase_led,
   output logic                     segment_led,
   output logic                     dark_cal_switch_open
);

   // ----------------------------------------------------------------
   // input conditioning
   // ----------------------------------------------------------------
   sensor_t raw;
   sensor_t lvl;
   sensor_t lvl_d;

   assign raw = '{dark_cal_req: dark_cal_req_in, timing_clk: timing_clk_in,
                  segment: segment_in, wheel_phase: wheel_phase_in};

   input_sync #(.WIDTH(4)) u_sync (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .raw_in    (raw),
      .level_out (lvl)
   );

   // previous conditioned levels for edge detection
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lvl_d <= '0;
      end else begin
         lvl_d <= lvl;
      end
   end

   logic       seg_edge;
   logic       seg_rise;
   logic       phase_rise;
   logic       tick;
   logic       settled;
   logic [2:0] settle_cnt;

   // sync chain holds reset zeros for a few cycles; a pin that is already
   // high at reset would look like an edge and open a gate mid-segment
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         settle_cnt <= 3'h0;
      end else if (!settled) begin
         settle_cnt <= settle_cnt + 3'h1;
      end
   end

   assign settled    = (settle_cnt == 3'(SYNC_STAGES + 2));
   assign seg_edge   = settled & (lvl.segment ^ lvl_d.segment);
   assign seg_rise   = settled & lvl.segment & ~lvl_d.segment;
   assign phase_rise = settled & lvl.wheel_phase & ~lvl_d.wheel_phase;
   assign tick       = settled & lvl.timing_clk & ~lvl_d.timing_clk; // enable pulse, not a clock

   // ----------------------------------------------------------------
   // tick counter since the last segment edge
   // ----------------------------------------------------------------
   logic [TICK_W-1:0] tick_cnt;

   // saturates so a stalled wheel never wraps back into the window
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tick_cnt <= TICK_MAX;
      end else if (seg_edge) begin
         tick_cnt <= '0;
      end else if (tick && tick_cnt != TICK_MAX) begin
         tick_cnt <= tick_cnt + 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // gate selection
   // ----------------------------------------------------------------
   logic  in_window;
   gate_t next_gates;

   // edge cycle is masked: count still holds the previous segment
   assign in_window = !seg_edge && tick_cnt >= GATE_START && tick_cnt < GATE_STOP;

   always_comb begin
      next_gates             = '0;
      next_gates.meas_bright = in_window &  lvl.wheel_phase &  lvl.segment;
      next_gates.meas_dark   = in_window &  lvl.wheel_phase & ~lvl.segment;
      next_gates.ref_bright  = in_window & ~lvl.wheel_phase &  lvl.segment;
      next_gates.ref_dark    = in_window & ~lvl.wheel_phase & ~lvl.segment;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gates <= '0;
      end else begin
         gates <= next_gates;
      end
   end

   // ----------------------------------------------------------------
   // peak capture and level hold, one lane per half
   // ----------------------------------------------------------------
   logic [1:0]          bright_g;
   logic [1:0]          dark_g;
   logic [1:0]          dark_end;
   logic [SAMPLE_W-1:0] level_q [2];

   assign bright_g = {gates.ref_bright, gates.meas_bright};
   assign dark_g   = {gates.ref_dark, gates.meas_dark};
   assign dark_end = dark_g & ~{next_gates.ref_dark, next_gates.meas_dark};

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_lane
         logic [SAMPLE_W-1:0] pk_bright;
         logic [SAMPLE_W-1:0] pk_dark;
         logic                bright_d;
         logic                dark_d;

         // peak tracking restarts on the first cycle of each gate
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               pk_bright <= '0;
               pk_dark   <= '0;
               bright_d  <= 1'b0;
               dark_d    <= 1'b0;
            end else begin
               bright_d <= bright_g[ch];
               dark_d   <= dark_g[ch];
               if (bright_g[ch] && (!bright_d || detector_sample > pk_bright)) begin
                  pk_bright <= detector_sample;
               end
               if (dark_g[ch] && (!dark_d || detector_sample > pk_dark)) begin
                  pk_dark <= detector_sample;
               end
            end
         end

         // level is bright minus dark, clipped at zero; updates as the dark gate closes
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               level_q[ch] <= '0;
            end else if (dark_end[ch]) begin
               level_q[ch] <= (pk_bright > pk_dark) ? pk_bright - pk_dark : '0;
            end
         end
      end
   endgenerate

   assign measure_level_out   = level_q[0];
   assign reference_level_out = level_q[1];

   // ----------------------------------------------------------------
   // rotation LEDs: stuck LED means the sensor stopped toggling
   // ----------------------------------------------------------------
   logic [LED_CNT_W-1:0] phase_div;
   logic [LED_CNT_W-1:0] seg_div;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         phase_div       <= '0;
         wheel_phase_led <= 1'b0;
      end else if (phase_rise) begin
         if (phase_div == LED_CNT_W'(PHASE_DIV - 1)) begin
            phase_div       <= '0;
            wheel_phase_led <= ~wheel_phase_led;
         end else begin
            phase_div <= phase_div + 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         seg_div     <= '0;
         segment_led <= 1'b0;
      end else if (seg_rise) begin
         if (seg_div == LED_CNT_W'(SEG_DIV - 1)) begin
            seg_div     <= '0;
            segment_led <= ~segment_led;
         end else begin
            seg_div <= seg_div + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // dark calibration switch, level driven by the host line
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dark_cal_switch_open <= 1'b0;
      end else begin
         dark_cal_switch_open <= lvl.dark_cal_req;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   AST_GATE_ONEHOT: assert property ($onehot0(gates))
      else $error("more than one gate active");
   AST_MEAS_BRIGHT: assert property (gates.meas_bright |-> $past(lvl.segment && lvl.wheel_phase))
      else $error("measure bright gate without its phase");
   AST_REF_DARK: assert property (gates.ref_dark |-> $past(!lvl.segment && !lvl.wheel_phase))
      else $error("reference dark gate without its phase");
   AST_WINDOW: assert property ((|gates) |-> $past(tick_cnt) >= GATE_START && $past(tick_cnt) < GATE_STOP)
      else $error("gate outside tick window");
   AST_EDGE_QUIET: assert property (seg_edge |=> gates == '0 ##1 gates == '0)
      else $error("gate active at segment edge");
   AST_TICK_ADV: assert property (tick && !seg_edge && tick_cnt != TICK_MAX |=> tick_cnt == $past(tick_cnt) + 4'h1)
      else $error("tick count did not advance");
   AST_LEVEL_HOLD: assert property (!dark_end[0] |=> $stable(measure_level_out))
      else $error("measure level changed outside dark gate end");
   AST_LED_HOLD: assert property (!phase_rise |=> $stable(wheel_phase_led))
      else $error("phase LED moved without phase edge");
   AST_DARK_SW: assert property ($rose(lvl.dark_cal_req) |=> dark_cal_switch_open [*2])
      else $error("dark switch did not open");

endmodule

// File: bench/wheel_host_model.sv
// model of the chopper wheel sensors, tenfold timing clock and host request line
`timescale 1ns/1ns
module wheel_host_model (
   // clock, reset and bench control
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic run,
   input  wire logic cal_cmd,
   // sensor pins and host request
   output logic      wheel_phase,
   output logic      segment,
   output logic      timing_clk,
   output logic      dark_cal_req
);
   logic [6:0] pos;
   logic [1:0] seg_num;

   // 80 cycles per segment period; frozen when stopped, so both pins stick
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pos <= 7'h00;
      end else if (run) begin
         pos <= (pos == 7'h4F) ? 7'h00 : pos + 7'h01;
      end
   end

   // phase level held for four whole segment periods
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         seg_num     <= 2'h0;
         wheel_phase <= 1'b1;
      end else if (run && pos == 7'h4F) begin
         seg_num <= seg_num + 2'h1;
         if (seg_num == 2'h3) begin
            wheel_phase <= ~wheel_phase;
         end
      end
   end

   // tick edges kept clear of segment edges: ticks at 2,10,..,34 in each half
   assign segment    = (pos < 7'h28);
   assign timing_clk = (pos[2:0] >= 3'h2) && (pos[2:0] < 3'h6);

   // host request passes one register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dark_cal_req <= 1'b0;
      end else begin
         dark_cal_req <= cal_cmd;
      end
   end
endmodule

// File: bench/chopper_wheel_demod_gate_timing_test.sv
// self-checking bench for the demodulator gate timing block
`timescale 1ns/1ns
module chopper_wheel_demod_gate_timing_test;
   import demod_gate_pkg::*;

   typedef struct packed {
      logic        ph;
      logic        sg;
      logic [3:0]  g;
      logic [11:0] lvl;
   } row_t;

   logic                sys_clk;
   logic                rst;
   logic                run;
   logic                cal_cmd;
   logic                swap;
   logic                wheel_phase;
   logic                segment;
   logic                timing_clk;
   logic                dark_cal_req;
   logic [SAMPLE_W-1:0] detector_sample;
   gate_t               gates;
   logic [SAMPLE_W-1:0] measure_level_out;
   logic [SAMPLE_W-1:0] reference_level_out;
   logic                wheel_phase_led;
   logic                segment_led;
   logic                dark_cal_switch_open;
   int                  fails;
   int                  cmp_count;
   logic                q;
   row_t                rows [4];

   wheel_host_model wheel_host_model_i (
      .sys_clk(sys_clk), .rst(rst), .run(run), .cal_cmd(cal_cmd),
      .wheel_phase(wheel_phase), .segment(segment), .timing_clk(timing_clk),
      .dark_cal_req(dark_cal_req));

   // small dividers keep the led checks short
   demod_gate_timing #(.PHASE_DIV(2), .SEG_DIV(2)) demod_gate_timing_i (
      .sys_clk(sys_clk), .rst(rst), .wheel_phase_in(wheel_phase),
      .segment_in(segment), .timing_clk_in(timing_clk),
      .dark_cal_req_in(dark_cal_req), .detector_sample(detector_sample),
      .gates(gates), .measure_level_out(measure_level_out),
      .reference_level_out(reference_level_out), .wheel_phase_led(wheel_phase_led),
      .segment_led(segment_led), .dark_cal_switch_open(dark_cal_switch_open));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // detector level follows the beam; swap makes reference dark exceed bright
   always @(posedge sys_clk) begin
      case ({wheel_phase, segment})
         2'b11:   detector_sample <= 12'h300;
         2'b10:   detector_sample <= 12'h100;
         2'b01:   detector_sample <= swap ? 12'h060 : 12'h2A0;
         default: detector_sample <= swap ? 12'h2A0 : 12'h060;
      endcase
   end

   task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic conclude();
      if (fails == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // bounded wait for a segment pin edge in the wanted phase half
   task automatic wait_edge(input logic ph, input logic sg);
      logic prev;
      prev = segment;
      for (int n = 0; n < 2000; n++) begin
         @(posedge sys_clk);
         if (segment !== prev && segment === sg && wheel_phase === ph) return;
         prev = segment;
      end
      fails++;
      $display("Error wait_edge expected %h seen %h", sg, segment);
   endtask

   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      rst = 1'b1;
      run = 1'b1;
      cal_cmd = 1'b0;
      swap = 1'b0;
      fails = 0;
      cmp_count = 0;
      rows[0] = '{1'b1, 1'b1, 4'h1, 12'h000};
      rows[1] = '{1'b1, 1'b0, 4'h2, 12'h200};
      rows[2] = '{1'b0, 1'b1, 4'h4, 12'h000};
      rows[3] = '{1'b0, 1'b0, 4'h8, 12'h240};
      repeat (2) @(posedge sys_clk);
      check("reset_gates", 12'h000, {8'h00, gates});
      check("reset_leds", 12'h000, {10'h000, wheel_phase_led, segment_led});
      rst <= 1'b0;
      repeat (20) @(posedge sys_clk);
      check("gates_before_edge", 12'h000, {8'h00, gates});
      for (int i = 0; i < 4; i++) begin
         wait_edge(rows[i].ph, rows[i].sg);
         repeat (3) @(posedge sys_clk);
         check("gates_early", 12'h000, {8'h00, gates});
         repeat (13) @(posedge sys_clk);
         check("gates", {8'h00, rows[i].g}, {8'h00, gates});
         repeat (20) @(posedge sys_clk);
         check("gates_late", 12'h000, {8'h00, gates});
         if (!rows[i].sg) begin
            check("level", rows[i].lvl, rows[i].ph ? measure_level_out
                                                   : reference_level_out);
         end
      end
      // reference result clipped at zero when dark exceeds bright
      swap <= 1'b1;
      wait_edge(1'b0, 1'b0);
      repeat (36) @(posedge sys_clk);
      check("level_clip", 12'h000, reference_level_out);
      check("level_held", 12'h200, measure_level_out);
      // host request opens the switch; a one-cycle blip is ignored
      // model register, three sync stages, the agreement flop and the output flop: six edges
      cal_cmd <= 1'b1;
      repeat (8) @(posedge sys_clk);
      check("switch_open", 12'h001, {11'h000, dark_cal_switch_open});
      cal_cmd <= 1'b0;
      repeat (8) @(posedge sys_clk);
      check("switch_closed", 12'h000, {11'h000, dark_cal_switch_open});
      cal_cmd <= 1'b1;
      @(posedge sys_clk);
      cal_cmd <= 1'b0;
      repeat (6) @(posedge sys_clk);
      check("switch_blip", 12'h000, {11'h000, dark_cal_switch_open});
      // one toggle per two rising edges of each sensor
      q = segment_led;
      repeat (160) @(posedge sys_clk);
      check("segment_led", {11'h000, ~q}, {11'h000, segment_led});
      q = wheel_phase_led;
      repeat (1280) @(posedge sys_clk);
      check("phase_led", {11'h000, ~q}, {11'h000, wheel_phase_led});
      // stopped wheel leaves the segment led stuck
      run <= 1'b0;
      repeat (10) @(posedge sys_clk);
      q = segment_led;
      repeat (300) @(posedge sys_clk);
      check("led_stuck", {11'h000, q}, {11'h000, segment_led});
      // reset with the wheel stopped clears the measure level output
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      check("rerun_level", 12'h000, measure_level_out);
      rst <= 1'b0;
      run <= 1'b1;
      // pins start high again: a second release must not fake a segment edge
      repeat (20) @(posedge sys_clk);
      check("rerun_gates", 12'h000, {8'h00, gates});
      check("rerun_leds", 12'h000, {10'h000, wheel_phase_led, segment_led});
      conclude();
   end

   // guard against a hung sequence; the tests need about 2300 cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      conclude();
   end
endmodule
